//--- fx_ecc.sv
`timescale 1ns/1ns
// ==========================================================================
// secded (72,64) encoder and checker
module fx_ecc (
  input  wire logic [fx_pkg::DATA_W-1:0] enc_data,
  output logic      [fx_pkg::CHK_W-1:0]  enc_check,
  input  wire logic [fx_pkg::WORD_W-1:0] dec_word,
  output logic      [fx_pkg::DATA_W-1:0] dec_data,
  output logic                           dec_single,
  output logic                           dec_double
);

  // codeword position of each data bit, skipping the powers of two
  function automatic logic [fx_pkg::HAM_W-1:0] fx_pos(input int j);
    int                       k;
    logic [fx_pkg::HAM_W-1:0] r;
    k = 0;
    r = 7'h00;
    for (int p = 3; p < 128; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (k == j) r = p[6:0];
        k++;
      end
    end
    return r;
  endfunction : fx_pos

  function automatic logic [fx_pkg::HAM_W-1:0] fx_ham(input logic [fx_pkg::DATA_W-1:0] d);
    logic [fx_pkg::HAM_W-1:0] r;
    logic [fx_pkg::HAM_W-1:0] p;
    r = 7'h00;
    for (int j = 0; j < fx_pkg::DATA_W; j++) begin
      p = fx_pos(j);
      for (int i = 0; i < fx_pkg::HAM_W; i++) begin
        if (p[i]) r[i] = r[i] ^ d[j];
      end
    end
    return r;
  endfunction : fx_ham

  // ==========================================================================
  // encode: overall bit makes the whole word even
  wire [fx_pkg::HAM_W-1:0] enc_ham = fx_ham(enc_data);
  assign enc_check = {^{enc_data, enc_ham}, enc_ham};

  // ==========================================================================
  // decode
  wire [fx_pkg::DATA_W-1:0] rx_data = dec_word[fx_pkg::DATA_W-1:0];
  wire [fx_pkg::HAM_W-1:0]  rx_ham  = dec_word[fx_pkg::DATA_W+fx_pkg::HAM_W-1:fx_pkg::DATA_W];
  wire [fx_pkg::HAM_W-1:0]  syndrome = rx_ham ^ fx_ham(rx_data);
  wire                      odd_word = ^dec_word;

  assign dec_single = odd_word;
  assign dec_double = !odd_word && (syndrome != 7'h00);

  for (genvar g = 0; g < fx_pkg::DATA_W; g++) begin : g_fix
    localparam logic [fx_pkg::HAM_W-1:0] POS = fx_pos(g);
    assign dec_data[g] = rx_data[g] ^ (odd_word && (syndrome == POS));
  end

endmodule : fx_ecc

//--- fx_flash_model.sv
`timescale 1ns/1ns
// ==========================================================================
// flash array stand-in: whole 72-bit words, answer lat+1 cycles after the command
module fx_flash_model (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  flash_valid,
  input  wire fx_pkg::fx_flash_cmd_t flash_cmd,
  input  wire logic [71:0]           flip,
  input  wire logic [3:0]            lat,
  output logic                       flash_done,
  output logic [71:0]                flash_rdata
);
  logic [71:0]           mem [logic [16:0]];
  fx_pkg::fx_flash_cmd_t cmd;
  logic [3:0]            cnt;
  logic                  busy;
  logic [16:0]           k;
  // read data toggles outside answers so a stale word never passes
  always @(posedge ref_clk) begin
    flash_done <= 1'b0;
    flash_rdata <= ~flash_rdata;
    k = cmd.addr[19:3];
    if (reset) begin
      busy <= 1'b0;
      flash_rdata <= '0;
    end else if (flash_valid) begin
      cmd <= flash_cmd;
      cnt <= lat;
      busy <= 1'b1;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      flash_done <= 1'b1;
      if (cmd.op == fx_pkg::FX_WRITE) mem[k] = cmd.wword;
      if (cmd.op == fx_pkg::FX_ERASE) begin
        // a 16-byte granule spans two words
        mem.delete(k);
        mem.delete(k + 17'h1);
      end
      flash_rdata <= (mem.exists(k) ? mem[k] : 72'h0) ^ flip;
    end
  end
endmodule : fx_flash_model

//--- fx_pkg.sv
// ==========================================================================
// shared constants and types
package fx_pkg;

  // ==========================================================================
  // widths
  localparam int ADDR_W     = 20;
  localparam int DATA_W     = 64;
  localparam int CHK_W      = 8;
  localparam int HAM_W      = 7;
  localparam int WORD_W     = 72;
  localparam int NUM_REGION = 2;
  localparam int STATUS_W   = 4;
  localparam int CTRL_W     = 4;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_LEVEL    = 8'h04;
  localparam logic [7:0] OFS_R0_START = 8'h08;
  localparam logic [7:0] OFS_R0_END   = 8'h0C;
  localparam logic [7:0] OFS_R1_START = 8'h10;
  localparam logic [7:0] OFS_R1_END   = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_MASK     = 8'h1C;
  localparam logic [7:0] OFS_ECC_ADDR = 8'h20;

  // ==========================================================================
  // field positions
  localparam int CTRL_DUAL      = 0;
  localparam int CTRL_ERASE_OPT = 1;
  localparam int CTRL_EN0       = 2;
  localparam int STAT_REFUSED   = 0;
  localparam int STAT_CORRECTED = 1;
  localparam int STAT_DOUBLE    = 2;
  localparam int STAT_WIPED     = 3;
  localparam int ECC_DBL_BIT    = 31;

  // ==========================================================================
  // reset values
  localparam logic [CTRL_W-1:0]   CTRL_RST   = 4'h0;
  localparam logic [STATUS_W-1:0] STATUS_RST = 4'h0;
  localparam logic [STATUS_W-1:0] MASK_RST   = 4'h0;
  localparam logic [ADDR_W-1:0]   ADDR_RST   = 20'h00000;

  // ==========================================================================
  // granule masks and steps
  localparam logic [ADDR_W-1:0] GRAN_MASK_SINGLE = 20'hFFFF0;
  localparam logic [ADDR_W-1:0] GRAN_MASK_DUAL   = 20'hFFFF8;
  localparam logic [ADDR_W-1:0] GRAN_STEP_SINGLE = 20'h00010;
  localparam logic [ADDR_W-1:0] GRAN_STEP_DUAL   = 20'h00008;

  // ==========================================================================
  // enumerations
  typedef enum logic [1:0] {
    FX_LVL0 = 2'b00,
    FX_LVL1 = 2'b01,
    FX_LVL2 = 2'b10
  } fx_level_t;

  typedef enum logic [1:0] {
    FX_CPU   = 2'b00,
    FX_DMA   = 2'b01,
    FX_DEBUG = 2'b10
  } fx_master_t;

  typedef enum logic [1:0] {
    FX_FETCH = 2'b00,
    FX_READ  = 2'b01,
    FX_WRITE = 2'b10,
    FX_ERASE = 2'b11
  } fx_op_t;

  typedef enum logic [1:0] {
    FX_IDLE      = 2'b00,
    FX_WAIT      = 2'b01,
    FX_WIPE_GO   = 2'b10,
    FX_WIPE_WAIT = 2'b11
  } fx_state_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    fx_master_t        master;
    fx_op_t            op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fx_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              refused;
    logic              corrected;
    logic              uncorrectable;
  } fx_rsp_t;

  typedef struct packed {
    fx_op_t            op;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wword;
  } fx_flash_cmd_t;

endpackage : fx_pkg

//--- fx_protect.sv
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module fx_protect (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               irq,
  input  wire logic                          req_valid,
  input  wire fx_pkg::fx_req_t               req,
  output logic                               req_ready,
  output logic                               rsp_valid,
  output fx_pkg::fx_rsp_t                    rsp,
  output logic                               flash_valid,
  output fx_pkg::fx_flash_cmd_t              flash_cmd,
  input  wire logic                          flash_done,
  input  wire logic [fx_pkg::WORD_W-1:0]     flash_rdata
);

  localparam int AW = fx_pkg::ADDR_W;

  // ==========================================================================
  // state
  fx_pkg::fx_state_t                 state;
  fx_pkg::fx_state_t                 next_state;
  fx_pkg::fx_level_t                 level;
  logic [fx_pkg::CTRL_W-1:0]         ctrl;
  logic [1:0][AW-1:0]                region_start;
  logic [1:0][AW-1:0]                region_end;
  logic [fx_pkg::STATUS_W-1:0]       status;
  logic [fx_pkg::STATUS_W-1:0]       mask;
  logic [AW-1:0]                     ecc_addr;
  logic                              ecc_dbl;
  logic                              wipe_pending;
  logic                              wipe_idx;
  logic                              next_wipe_idx;
  logic [AW-1:0]                     wipe_addr;
  logic [AW-1:0]                     next_wipe_addr;
  fx_pkg::fx_op_t                    pend_op;
  logic [AW-1:0]                     pend_addr;
  fx_pkg::fx_rsp_t                   next_rsp;
  logic                              rsp_set;
  logic                              issue;
  fx_pkg::fx_flash_cmd_t             next_cmd;
  logic                              wipe_take;
  logic                              wipe_finish;
  logic                              ecc_capture;
  logic [fx_pkg::STATUS_W-1:0]       events;

  // ==========================================================================
  // ecc
  logic [fx_pkg::CHK_W-1:0]          wr_check;
  logic [fx_pkg::DATA_W-1:0]         fixed_data;
  logic                              ecc_single;
  logic                              ecc_double;

  fx_ecc u_ecc (
    .enc_data   (req.wdata),
    .enc_check  (wr_check),
    .dec_word   (flash_rdata),
    .dec_data   (fixed_data),
    .dec_single (ecc_single),
    .dec_double (ecc_double)
  );

  // ==========================================================================
  // region match
  wire            dual      = ctrl[fx_pkg::CTRL_DUAL];
  wire            erase_region_on_unprotect = ctrl[fx_pkg::CTRL_ERASE_OPT];
  wire [1:0]      region_en = ctrl[fx_pkg::CTRL_EN0+1:fx_pkg::CTRL_EN0];
  wire [AW-1:0]   gran_mask = dual ? fx_pkg::GRAN_MASK_DUAL : fx_pkg::GRAN_MASK_SINGLE;
  wire [AW-1:0]   gran_step = dual ? fx_pkg::GRAN_STEP_DUAL : fx_pkg::GRAN_STEP_SINGLE;
  wire [AW-1:0]   req_gran  = req.addr & gran_mask;
  logic [1:0][AW-1:0] region_lo;
  logic [1:0][AW-1:0] region_hi;
  logic [1:0]         req_hit;

  for (genvar i = 0; i < fx_pkg::NUM_REGION; i++) begin : g_region
    assign region_lo[i] = region_start[i] & gran_mask;
    assign region_hi[i] = region_end[i] & gran_mask;
    // in dual bank each region is tied to its own bank
    assign req_hit[i]   = region_en[i] && (req_gran >= region_lo[i])
                          && (req_gran <= region_hi[i])
                          && (!dual || (req.addr[AW-1] == 1'(i)));
  end

  wire is_fetch    = (req.master == fx_pkg::FX_CPU) && (req.op == fx_pkg::FX_FETCH);
  wire req_refused = (|req_hit) && !is_fetch;
  wire req_take    = req_valid && req_ready;
  wire pend_is_rd  = (pend_op == fx_pkg::FX_FETCH) || (pend_op == fx_pkg::FX_READ);

  // ==========================================================================
  // apb decode
  wire apb_setup  = psel && !penable;
  wire apb_access = psel && penable;
  wire hit_ctrl   = (paddr == fx_pkg::OFS_CTRL);
  wire hit_level  = (paddr == fx_pkg::OFS_LEVEL);
  wire hit_r0s    = (paddr == fx_pkg::OFS_R0_START);
  wire hit_r0e    = (paddr == fx_pkg::OFS_R0_END);
  wire hit_r1s    = (paddr == fx_pkg::OFS_R1_START);
  wire hit_r1e    = (paddr == fx_pkg::OFS_R1_END);
  wire hit_status = (paddr == fx_pkg::OFS_STATUS);
  wire hit_mask   = (paddr == fx_pkg::OFS_MASK);
  wire hit_ecc    = (paddr == fx_pkg::OFS_ECC_ADDR);
  wire addr_ok    = hit_ctrl || hit_level || hit_r0s || hit_r0e || hit_r1s
                    || hit_r1e || hit_status || hit_mask || hit_ecc;
  wire apb_wr     = apb_access && pwrite && addr_ok;
  // region setup is frozen once protection is raised, so untrusted code cannot
  // shrink a region before reading it
  wire wiping     = (state == fx_pkg::FX_WIPE_GO) || (state == fx_pkg::FX_WIPE_WAIT);
  wire cfg_open   = (level == fx_pkg::FX_LVL0) && !wipe_pending && !wiping;
  wire cfg_wr     = apb_wr && cfg_open;
  wire lvl_valid  = (pwdata[1:0] != 2'b11);
  // level two is final: no write can leave it
  wire lvl_wr     = apb_wr && hit_level && lvl_valid && (level != fx_pkg::FX_LVL2);
  wire lower_1to0 = lvl_wr && (level == fx_pkg::FX_LVL1)
                    && (pwdata[1:0] == fx_pkg::FX_LVL0);
  wire wipe_req   = lower_1to0 && erase_region_on_unprotect && (|region_en);
  wire [fx_pkg::STATUS_W-1:0] st_clear =
    (apb_wr && hit_status) ? pwdata[fx_pkg::STATUS_W-1:0] : 4'h0;

  wire [31:0] rd_mux =
    hit_ctrl   ? {28'h0000000, ctrl} :
    hit_level  ? {30'h00000000, level} :
    hit_r0s    ? {12'h000, region_start[0]} :
    hit_r0e    ? {12'h000, region_end[0]} :
    hit_r1s    ? {12'h000, region_start[1]} :
    hit_r1e    ? {12'h000, region_end[1]} :
    hit_status ? {28'h0000000, status} :
    hit_mask   ? {28'h0000000, mask} :
    hit_ecc    ? {ecc_dbl, 11'h000, ecc_addr} :
    32'h00000000;

  assign pready    = 1'b1;
  assign pslverr   = apb_access && !addr_ok;
  assign req_ready = (state == fx_pkg::FX_IDLE) && !wipe_pending;
  assign irq       = |(status & mask);

  // ==========================================================================
  // sequencer
  always_comb begin
    next_state     = state;
    next_wipe_idx  = wipe_idx;
    next_wipe_addr = wipe_addr;
    next_rsp       = rsp;
    next_cmd       = flash_cmd;
    rsp_set        = 1'b0;
    issue          = 1'b0;
    wipe_take      = 1'b0;
    wipe_finish    = 1'b0;
    ecc_capture    = 1'b0;
    events         = 4'h0;
    case (state)
      fx_pkg::FX_IDLE: begin
        if (wipe_pending) begin
          wipe_take      = 1'b1;
          next_wipe_idx  = 1'b0;
          next_wipe_addr = region_lo[0];
          next_state     = fx_pkg::FX_WIPE_GO;
        end else if (req_take && req_refused) begin
          // no flash cycle at all, and the answer carries no data
          rsp_set  = 1'b1;
          next_rsp = '{rdata: '0, refused: 1'b1, corrected: 1'b0,
                       uncorrectable: 1'b0};
          events[fx_pkg::STAT_REFUSED] = 1'b1;
        end else if (req_take) begin
          issue      = 1'b1;
          next_cmd   = '{op: req.op, addr: req.addr, wword: {wr_check, req.wdata}};
          next_state = fx_pkg::FX_WAIT;
        end
      end
      fx_pkg::FX_WAIT: begin
        if (flash_done) begin
          rsp_set    = 1'b1;
          next_state = fx_pkg::FX_IDLE;
          next_rsp   = '{rdata: '0, refused: 1'b0, corrected: 1'b0,
                         uncorrectable: 1'b0};
          if (pend_is_rd) begin
            // a word that cannot be repaired is not passed on
            next_rsp.rdata         = ecc_double ? '0 : fixed_data;
            next_rsp.corrected     = ecc_single;
            next_rsp.uncorrectable = ecc_double;
            events[fx_pkg::STAT_CORRECTED] = ecc_single;
            events[fx_pkg::STAT_DOUBLE]    = ecc_double;
            ecc_capture = ecc_single || ecc_double;
          end
        end
      end
      fx_pkg::FX_WIPE_GO: begin
        if (!region_en[wipe_idx]) begin
          if (wipe_idx) begin
            wipe_finish = 1'b1;
          end else begin
            next_wipe_idx  = 1'b1;
            next_wipe_addr = region_lo[1];
          end
        end else begin
          issue      = 1'b1;
          next_cmd   = '{op: fx_pkg::FX_ERASE, addr: wipe_addr, wword: '0};
          next_state = fx_pkg::FX_WIPE_WAIT;
        end
      end
      fx_pkg::FX_WIPE_WAIT: begin
        if (flash_done) begin
          next_state = fx_pkg::FX_WIPE_GO;
          if (wipe_addr < region_hi[wipe_idx]) begin
            next_wipe_addr = wipe_addr + gran_step;
          end else if (wipe_idx) begin
            wipe_finish = 1'b1;
          end else begin
            next_wipe_idx  = 1'b1;
            next_wipe_addr = region_lo[1];
          end
        end
      end
      default: begin
        next_state = fx_pkg::FX_IDLE;
      end
    endcase
    if (wipe_finish) begin
      next_state = fx_pkg::FX_IDLE;
      events[fx_pkg::STAT_WIPED] = 1'b1;
    end
  end

  // ==========================================================================
  // sequencer registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state     <= fx_pkg::FX_IDLE;
      wipe_idx  <= 1'b0;
      wipe_addr <= fx_pkg::ADDR_RST;
    end else begin
      state     <= next_state;
      wipe_idx  <= next_wipe_idx;
      wipe_addr <= next_wipe_addr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend_op   <= fx_pkg::FX_FETCH;
      pend_addr <= fx_pkg::ADDR_RST;
    end else if (issue) begin
      pend_op   <= next_cmd.op;
      pend_addr <= next_cmd.addr;
    end
  end

  // refused requests never reach this point, so the array is untouched
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flash_valid <= 1'b0;
      flash_cmd   <= '0;
    end else begin
      flash_valid <= issue;
      flash_cmd   <= next_cmd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      rsp_valid <= rsp_set;
      rsp       <= next_rsp;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl <= fx_pkg::CTRL_RST;
    end else if (wipe_finish) begin
      // erased regions no longer need guarding
      ctrl[fx_pkg::CTRL_EN0+1:fx_pkg::CTRL_EN0] <= 2'b00;
    end else if (cfg_wr && hit_ctrl) begin
      ctrl <= pwdata[fx_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      region_start <= '0;
      region_end   <= '0;
    end else if (cfg_wr) begin
      if (hit_r0s) region_start[0] <= pwdata[AW-1:0];
      if (hit_r0e) region_end[0]   <= pwdata[AW-1:0];
      if (hit_r1s) region_start[1] <= pwdata[AW-1:0];
      if (hit_r1e) region_end[1]   <= pwdata[AW-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      level        <= fx_pkg::FX_LVL0;
      wipe_pending <= 1'b0;
    end else begin
      if (lvl_wr) level <= fx_pkg::fx_level_t'(pwdata[1:0]);
      wipe_pending <= wipe_req || (wipe_pending && !wipe_take);
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status <= fx_pkg::STATUS_RST;
      mask   <= fx_pkg::MASK_RST;
    end else begin
      status <= (status & ~st_clear) | events;
      if (apb_wr && hit_mask) mask <= pwdata[fx_pkg::STATUS_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ecc_addr <= fx_pkg::ADDR_RST;
      ecc_dbl  <= 1'b0;
    end else if (ecc_capture) begin
      ecc_addr <= pend_addr;
      ecc_dbl  <= ecc_double;
    end
  end

  // read data latched in the setup phase, stable through the access phase
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      prdata <= rd_mux;
    end
  end

endmodule : fx_protect

//--- fx_protect_checker.sv
`timescale 1ns/1ns
// ==========================================================================
// port checker for the protection filter
module fx_protect_checker (
  input wire logic                  ref_clk,
  input wire logic                  reset,
  input wire logic                  req_valid,
  input wire fx_pkg::fx_req_t       req,
  input wire logic                  req_ready,
  input wire logic                  rsp_valid,
  input wire fx_pkg::fx_rsp_t       rsp,
  input wire logic                  flash_valid,
  input wire fx_pkg::fx_flash_cmd_t flash_cmd,
  input wire logic                  flash_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire take = req_valid && req_ready;

  a_take_one_path: assert property (take |=> flash_valid != (rsp_valid && rsp.refused))
    else $error("taken request neither refused nor sent to flash");
  a_cmd_follows_req: assert property (take ##1 flash_valid |->
    flash_cmd.addr == $past(req.addr) && flash_cmd.op == $past(req.op))
    else $error("flash command differs from request");
  a_refused_empty: assert property (rsp_valid && rsp.refused |->
    rsp.rdata == '0 && !flash_valid)
    else $error("refused answer carries data");
  a_answer_after_done: assert property (rsp_valid && !rsp.refused |-> $past(flash_done))
    else $error("answer without flash completion");
  a_double_zeroed: assert property (rsp_valid && rsp.uncorrectable |->
    rsp.rdata == '0 && !rsp.corrected)
    else $error("double error answer not zeroed");
  a_busy_no_take: assert property (flash_valid |-> !req_ready)
    else $error("request accepted while flash busy");
  a_wipe_erase_only: assert property (flash_valid && !$past(take) |->
    flash_cmd.op == fx_pkg::FX_ERASE)
    else $error("unrequested flash command is not an erase");
  a_cmd_one_cycle: assert property (flash_valid |=> !flash_valid)
    else $error("flash command longer than one cycle");
endmodule : fx_protect_checker

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic                  ref_clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata;
  logic                  req_valid, req_ready, rsp_valid, flash_valid, flash_done;
  fx_pkg::fx_req_t       req;
  fx_pkg::fx_rsp_t       rsp;
  fx_pkg::fx_flash_cmd_t flash_cmd;
  logic [71:0]           flash_rdata, flip;
  logic [3:0]            lat;
  logic [63:0]           d0, d1, d2;
  logic [67:0]           e;
  logic [32:0]           aq[$];
  logic [67:0]           rq_q[$];
  logic [31:0]           lf = 32'h000105B4;
  int                    n_errors = 0;
  int                    checked = 0;

  always #5 ref_clk = ~ref_clk;
  fx_protect i_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .flash_valid(flash_valid), .flash_cmd(flash_cmd),
    .flash_done(flash_done), .flash_rdata(flash_rdata));
  fx_flash_model i_mem (.ref_clk(ref_clk), .reset(reset), .flash_valid(flash_valid),
    .flash_cmd(flash_cmd), .flip(flip), .lat(lat), .flash_done(flash_done),
    .flash_rdata(flash_rdata));

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic logic [63:0] rnd();
    lf = nx(lf);
    rnd[63:32] = lf;
    lf = nx(lf);
    rnd[31:0] = lf;
  endfunction : rnd

  task automatic report_and_stop();
    $display("n_errors %0d checked %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic cmp(input logic [66:0] got, input logic [66:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      report_and_stop();
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic er);
    aq.push_back({er, d});
    apb(1'b0, a, 32'h0);
  endtask : rd
  // f: compare data, refused, corrected, uncorrectable; a refused answer must carry zero data
  task automatic rq(input logic [1:0] m, input logic [1:0] o, input logic [19:0] a,
                    input logic [63:0] x, input logic [3:0] f);
    int n;
    n = 0;
    rq_q.push_back({f[3] | f[2], f[2] ? 64'h0 : x, f[2:0]});
    lf = nx(lf);
    @(posedge ref_clk);
    lat <= {2'h0, lf[1:0]};
    req_valid <= 1'b1;
    req <= '{fx_pkg::fx_master_t'(m), fx_pkg::fx_op_t'(o), a, x};
    do begin
      @(posedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 500);
    req_valid <= 1'b0;
    while (rq_q.size() > 0 && n < 600) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 600) begin
      n_errors++;
      report_and_stop();
    end
  endtask : rq
  task automatic chk_irq(input logic v);
    @(negedge ref_clk);
    cmp({66'h0, irq}, {66'h0, v});
  endtask : chk_irq

  // ==========================================================================
  // monitors: oldest note against each result
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite) cmp({34'h0, pslverr, prdata}, {34'h0, aq.pop_front()});
    if (rsp_valid === 1'b1) begin
      e = rq_q.pop_front();
      cmp(e[67] ? rsp : {64'h0, rsp[2:0]}, e[67] ? e[66:0] : {64'h0, e[2:0]});
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req_valid = 1'b0;
    req = '0;
    flip = 72'h0;
    lat = 4'h0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    rd(8'h00, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b0);
    rd(8'h24, 32'h0, 1'b1);
    d0 = rnd();
    d1 = rnd();
    rq(2'h0, 2'h2, 20'h00100, d0, 4'h0);
    rq(2'h0, 2'h2, 20'h00200, d1, 4'h0);
    apb(1'b1, 8'h08, 32'h0000010C);
    apb(1'b1, 8'h0C, 32'h000001F0);
    apb(1'b1, 8'h10, 32'h00000200);
    apb(1'b1, 8'h14, 32'h0000020F);
    apb(1'b1, 8'h00, 32'h0000000E);
    // every master and operation against a protected word
    for (int m = 0; m < 3; m++)
      for (int o = 0; o < 4; o++)
        if (m == 0 && o == 0) rq(2'h0, 2'h0, 20'h00100, d0, 4'h8);
        else rq(m[1:0], o[1:0], 20'h00100, rnd(), 4'h4);
    rq(2'h0, 2'h0, 20'h00100, d0, 4'h8);
    apb(1'b1, 8'h00, 32'h00000005);
    rq(2'h1, 2'h1, 20'h00100, d0, 4'h8);
    rq(2'h1, 2'h1, 20'h00108, 64'h0, 4'h4);
    apb(1'b1, 8'h00, 32'h0000000E);
    d2 = rnd();
    rq(2'h1, 2'h2, 20'h00040, d2, 4'h0);
    flip <= 72'h20;
    rq(2'h1, 2'h1, 20'h00040, d2, 4'hA);
    flip <= 72'h3;
    rq(2'h2, 2'h1, 20'h00040, 64'h0, 4'h9);
    flip <= 72'h0;
    rd(8'h20, 32'h80000040, 1'b0);
    rd(8'h18, 32'h00000007, 1'b0);
    chk_irq(1'b0);
    apb(1'b1, 8'h1C, 32'h00000002);
    chk_irq(1'b1);
    apb(1'b1, 8'h18, 32'h0000000F);
    chk_irq(1'b0);
    // with the erase option clear, lowering the level keeps the regions
    apb(1'b1, 8'h00, 32'h0000000C);
    apb(1'b1, 8'h04, 32'h00000001);
    apb(1'b1, 8'h04, 32'h00000000);
    rq(2'h0, 2'h0, 20'h00100, d0, 4'h8);
    rd(8'h18, 32'h00000000, 1'b0);
    apb(1'b1, 8'h00, 32'h0000000E);
    // lowering the level with the erase option set wipes both regions
    apb(1'b1, 8'h04, 32'h00000001);
    apb(1'b1, 8'h04, 32'h00000000);
    rq(2'h0, 2'h0, 20'h00100, 64'h0, 4'h8);
    rq(2'h0, 2'h0, 20'h00200, 64'h0, 4'h8);
    rd(8'h18, 32'h00000008, 1'b0);
    rd(8'h00, 32'h00000002, 1'b0);
    report_and_stop();
  end
endmodule : tb_top

bind fx_protect fx_protect_checker i_chk (.ref_clk(ref_clk), .reset(reset),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp(rsp), .flash_valid(flash_valid), .flash_cmd(flash_cmd), .flash_done(flash_done));
